/* src/amgirq_defs.svh */
// Purpose: Offsets, reset values, write masks, field positions and timing for the gate, low-voltage and mask registers
// Assumes: 8-bit control port registers on page zero
// Notes: Included by bare name
`ifndef AMGIRQ_DEFS_SVH
`define AMGIRQ_DEFS_SVH

`define AMG_CLK_HZ 40000000
`define AMG_US_PER_S 1000000
`define AMG_US_CYCLES (`AMG_CLK_HZ / `AMG_US_PER_S)
`define AMG_US_PER_MS 1000
`define AMG_SAMPLES_PER_MS 48

// Register offsets
`define AMG_OFS_GATE 8'h35
`define AMG_OFS_RAMP_LVHYS 8'h36
`define AMG_OFS_LVTH 8'h37
`define AMG_OFS_PULLDOWN 8'h38
`define AMG_OFS_BO_MASK 8'h3b
`define AMG_OFS_CRC_MASK 8'h3c
`define AMG_OFS_CLK_MASK 8'h3d
`define AMG_OFS_TEMP_MASK 8'h40
`define AMG_OFS_THERM_MASK 8'h41

// Reset values (reserved read-only bits read back these)
`define AMG_RST_GATE 8'hbd
`define AMG_RST_RAMP_LVHYS 8'had
`define AMG_RST_LVTH 8'ha8
`define AMG_RST_PULLDOWN 8'h00
`define AMG_RST_BO_MASK 8'hfc
`define AMG_RST_CRC_MASK 8'hbb
`define AMG_RST_CLK_MASK 8'hdd
`define AMG_RST_TEMP_MASK 8'hf6
`define AMG_RST_THERM_MASK 8'h14

// Writable bits per register
`define AMG_WM_GATE 8'hfc
`define AMG_WM_RAMP_LVHYS 8'hef
`define AMG_WM_LVTH 8'h9f
`define AMG_WM_PULLDOWN 8'h7c
`define AMG_WM_BO_MASK 8'hff
`define AMG_WM_CRC_MASK 8'h41
`define AMG_WM_CLK_MASK 8'h80
`define AMG_WM_TEMP_MASK 8'hf9
`define AMG_WM_THERM_MASK 8'hfc

// Field positions
`define AMG_F_HOLD_HI 7
`define AMG_F_HOLD_LO 5
`define AMG_F_LEVEL_HI 4
`define AMG_F_LEVEL_LO 3
`define AMG_F_GATE_EN 2
`define AMG_F_RAMP_OFF 5
`define AMG_F_LVHYS_HI 3
`define AMG_F_LVHYS_LO 0
`define AMG_F_LVMODE 7
`define AMG_F_LVFTH_HI 4
`define AMG_F_LVFTH_LO 0
`define AMG_F_PD_HI 6
`define AMG_F_PD_LO 2

// Mask bit positions inside their registers
`define AMG_B_BO_MUTE 7
`define AMG_B_BO_INFHOLD 6
`define AMG_B_CRC 6
`define AMG_B_LIMITER 0
`define AMG_B_CLKERR 7
`define AMG_B_TEMP1 7
`define AMG_B_TEMP2 6
`define AMG_B_TEMP3 5
`define AMG_B_TEMP4 4
`define AMG_B_REG_UV 3
`define AMG_B_HIGH_UV 0
`define AMG_B_TDTH2 7
`define AMG_B_TDTH1 6
`define AMG_B_RAILDIFF 5
`define AMG_B_BO_ACTIVE 4
`define AMG_B_BO_DETECT 3
`define AMG_B_BO_PDSTART 2

// Interrupt source indices
`define AMG_NSRC 17
`define AMG_E_BO_MUTE 0
`define AMG_E_BO_INFHOLD 1
`define AMG_E_CRC 2
`define AMG_E_LIMITER 3
`define AMG_E_CLKERR 4
`define AMG_E_TEMP1 5
`define AMG_E_TEMP2 6
`define AMG_E_TEMP3 7
`define AMG_E_TEMP4 8
`define AMG_E_REG_UV 9
`define AMG_E_HIGH_UV 10
`define AMG_E_TDTH2 11
`define AMG_E_TDTH1 12
`define AMG_E_RAILDIFF 13
`define AMG_E_BO_ACTIVE 14
`define AMG_E_BO_DETECT 15
`define AMG_E_BO_PDSTART 16

// Gate entry hold times in microseconds
`define AMG_HOLD_US0 400
`define AMG_HOLD_US1 600
`define AMG_HOLD_US2 800
`define AMG_HOLD_US3 2000
`define AMG_HOLD_US4 10000
`define AMG_HOLD_US5 50000
`define AMG_HOLD_US6 100000
`define AMG_HOLD_US7 1000000

// Low-voltage hysteresis times in milliseconds, codes a..f
`define AMG_LVHYS_FIRST 4'ha
`define AMG_LVHYS_MS_A 1
`define AMG_LVHYS_MS_B 10
`define AMG_LVHYS_MS_C 20
`define AMG_LVHYS_MS_D 50
`define AMG_LVHYS_MS_E 75
`define AMG_LVHYS_MS_F 100

`define AMG_TIMER_W 24

`endif

/* src/amgirq_pkg.sv */
// Purpose: Types used by the register bank; its hold timer declares its own widths
// Assumes: Constants come from amgirq_defs.svh
// Notes: Nothing here is imported; uses are scoped
package amgirq_pkg;
	typedef logic [7:0] amgirq_byte_t;
	typedef logic [23:0] amgirq_count_t;
	typedef logic [16:0] amgirq_src_t;
endpackage

/* src/amgirq_hold_timer.sv */
// Purpose: Counts ticks while a condition holds and flags expiry
// Assumes: Tick and condition come from logic on the same clock
// Notes: Count saturates; a drop of the condition restarts it
`timescale 1ns/1ps
module amgirq_hold_timer #(
	parameter int CW = 24
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic arm_i,
	input wire logic tick_i,
	input wire logic [CW-1:0] target_i,
	output logic expired_o
);
	logic [CW-1:0] count_reg;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || !arm_i)
			count_reg <= '0;
		else if (tick_i && count_reg < target_i)
			count_reg <= count_reg + 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || !arm_i)
			expired_o <= 1'b0;
		else
			expired_o <= (count_reg >= target_i);
	end
endmodule

/* src/amgirq_regs.sv */
// Purpose: Gate, low-voltage signalling, pin pull-down and interrupt mask registers
// Assumes: Control port write/read strobes, detectors and events are on mclk_i
// Notes: Reads answer one cycle after the read strobe
//
// Overview of operation
// - Hold-time code 0..7 picks 400us..1s, reset 5
// - Level code picks -90..-120 dBFS, reset 3
// - Gate works only while enable bit set
// - Ramp-off bit one disables volume ramping
// - Hysteresis codes A..F give 1..100 ms
// - Below 48 ksps stretch hysteresis by 48/fs
// - Mode bit: zero fixed, one rail-relative
// - Fixed threshold code, 0.25 dB steps, reset 08h
// - Five bits enable weak pin pull-downs
// - Brownout mute and infinite-hold masks, reset masked
// - CRC mask resets clear, limiter mask set
// - Loop clock error mask, register resets DDh
// - Four over-temperature masks, reset masked
// - Regulator and high-rail undervoltage masks
// - Thermal threshold two and one masks
// - Rail difference low mask, reset clear
// - Brownout active, detected, power-down-start masks
// - Every source keeps its own latched flag
`timescale 1ns/1ps
`include "amgirq_defs.svh"
module amgirq_regs #(
	parameter int US_TICK_CYCLES = `AMG_US_CYCLES,
	parameter int SAMPLES_PER_MS = `AMG_SAMPLES_PER_MS
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic silence_i,
	input wire logic lowvolt_cond_i,
	input wire logic fs_below_48k_i,
	input wire logic sample_tick_i,
	input wire logic [16:0] event_i,
	input wire logic flag_clear_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rd_valid_o,
	output logic gate_active_o,
	output logic [1:0] gate_level_threshold_o,
	output logic gate_volume_ramp_off_o,
	output logic lowvolt_threshold_mode_o,
	output logic [4:0] lowvolt_fixed_threshold_o,
	output logic lowvolt_active_o,
	output logic [4:0] pin_weak_pulldown_o,
	output logic [16:0] latched_flags_o,
	output logic irq_o
);
	amgirq_pkg::amgirq_byte_t gate_reg;
	amgirq_pkg::amgirq_byte_t ramp_lvhys_reg;
	amgirq_pkg::amgirq_byte_t lvth_reg;
	amgirq_pkg::amgirq_byte_t pulldown_reg;
	amgirq_pkg::amgirq_byte_t bo_mask_reg;
	amgirq_pkg::amgirq_byte_t crc_mask_reg;
	amgirq_pkg::amgirq_byte_t clk_mask_reg;
	amgirq_pkg::amgirq_byte_t temp_mask_reg;
	amgirq_pkg::amgirq_byte_t therm_mask_reg;
	amgirq_pkg::amgirq_src_t mask_vec;
	amgirq_pkg::amgirq_src_t flags_next;
	amgirq_pkg::amgirq_count_t hold_target;
	amgirq_pkg::amgirq_count_t lvhys_target;
	logic [15:0] us_div_reg;
	logic us_tick_reg;
	logic gate_expired;
	logic lv_expired;
	logic lv_tick;

	// Reset images for the mirrored outputs
	localparam amgirq_pkg::amgirq_byte_t RST_GATE_IMG = `AMG_RST_GATE;
	localparam amgirq_pkg::amgirq_byte_t RST_RAMP_IMG = `AMG_RST_RAMP_LVHYS;
	localparam amgirq_pkg::amgirq_byte_t RST_LVTH_IMG = `AMG_RST_LVTH;
	localparam amgirq_pkg::amgirq_byte_t RST_PD_IMG = `AMG_RST_PULLDOWN;

	// Merge writable bits with fixed reserved values
	function automatic amgirq_pkg::amgirq_byte_t merge_bits(input amgirq_pkg::amgirq_byte_t wval,
		input amgirq_pkg::amgirq_byte_t rstv, input amgirq_pkg::amgirq_byte_t wmask);
		merge_bits = (wval & wmask) | (rstv & ~wmask);
	endfunction

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = reg_wr_i && (reg_addr_i == ofs);
	endfunction

	function automatic amgirq_pkg::amgirq_count_t hold_us(input logic [2:0] code);
		case (code)
			3'h0: hold_us = 24'(`AMG_HOLD_US0);
			3'h1: hold_us = 24'(`AMG_HOLD_US1);
			3'h2: hold_us = 24'(`AMG_HOLD_US2);
			3'h3: hold_us = 24'(`AMG_HOLD_US3);
			3'h4: hold_us = 24'(`AMG_HOLD_US4);
			3'h5: hold_us = 24'(`AMG_HOLD_US5);
			3'h6: hold_us = 24'(`AMG_HOLD_US6);
			default: hold_us = 24'(`AMG_HOLD_US7);
		endcase
	endfunction

	// Reserved codes behave as the shortest time
	function automatic amgirq_pkg::amgirq_count_t lvhys_ms(input logic [3:0] code);
		case (code)
			4'hb: lvhys_ms = 24'(`AMG_LVHYS_MS_B);
			4'hc: lvhys_ms = 24'(`AMG_LVHYS_MS_C);
			4'hd: lvhys_ms = 24'(`AMG_LVHYS_MS_D);
			4'he: lvhys_ms = 24'(`AMG_LVHYS_MS_E);
			4'hf: lvhys_ms = 24'(`AMG_LVHYS_MS_F);
			default: lvhys_ms = 24'(`AMG_LVHYS_MS_A);
		endcase
	endfunction

	// Gate configuration register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			gate_reg <= `AMG_RST_GATE;
		else if (wr_hit(`AMG_OFS_GATE))
			gate_reg <= merge_bits(reg_wdata_i, `AMG_RST_GATE, `AMG_WM_GATE);
	end

	// Ramp and low-voltage hysteresis register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			ramp_lvhys_reg <= `AMG_RST_RAMP_LVHYS;
		else if (wr_hit(`AMG_OFS_RAMP_LVHYS))
			ramp_lvhys_reg <= merge_bits(reg_wdata_i, `AMG_RST_RAMP_LVHYS, `AMG_WM_RAMP_LVHYS);
	end

	// Low-voltage threshold register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			lvth_reg <= `AMG_RST_LVTH;
		else if (wr_hit(`AMG_OFS_LVTH))
			lvth_reg <= merge_bits(reg_wdata_i, `AMG_RST_LVTH, `AMG_WM_LVTH);
	end

	// Pin pull-down register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			pulldown_reg <= `AMG_RST_PULLDOWN;
		else if (wr_hit(`AMG_OFS_PULLDOWN))
			pulldown_reg <= merge_bits(reg_wdata_i, `AMG_RST_PULLDOWN, `AMG_WM_PULLDOWN);
	end

	// Interrupt mask registers
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			bo_mask_reg <= `AMG_RST_BO_MASK;
			crc_mask_reg <= `AMG_RST_CRC_MASK;
			clk_mask_reg <= `AMG_RST_CLK_MASK;
			temp_mask_reg <= `AMG_RST_TEMP_MASK;
			therm_mask_reg <= `AMG_RST_THERM_MASK;
		end
		else
		begin
			if (wr_hit(`AMG_OFS_BO_MASK))
				bo_mask_reg <= merge_bits(reg_wdata_i, `AMG_RST_BO_MASK, `AMG_WM_BO_MASK);
			if (wr_hit(`AMG_OFS_CRC_MASK))
				crc_mask_reg <= merge_bits(reg_wdata_i, `AMG_RST_CRC_MASK, `AMG_WM_CRC_MASK);
			if (wr_hit(`AMG_OFS_CLK_MASK))
				clk_mask_reg <= merge_bits(reg_wdata_i, `AMG_RST_CLK_MASK, `AMG_WM_CLK_MASK);
			if (wr_hit(`AMG_OFS_TEMP_MASK))
				temp_mask_reg <= merge_bits(reg_wdata_i, `AMG_RST_TEMP_MASK, `AMG_WM_TEMP_MASK);
			if (wr_hit(`AMG_OFS_THERM_MASK))
				therm_mask_reg <= merge_bits(reg_wdata_i, `AMG_RST_THERM_MASK, `AMG_WM_THERM_MASK);
		end
	end

	// Read port
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= 8'h00;
			reg_rd_valid_o <= 1'b0;
		end
		else
		begin
			reg_rd_valid_o <= reg_rd_i;
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					`AMG_OFS_GATE: reg_rdata_o <= gate_reg;
					`AMG_OFS_RAMP_LVHYS: reg_rdata_o <= ramp_lvhys_reg;
					`AMG_OFS_LVTH: reg_rdata_o <= lvth_reg;
					`AMG_OFS_PULLDOWN: reg_rdata_o <= pulldown_reg;
					`AMG_OFS_BO_MASK: reg_rdata_o <= bo_mask_reg;
					`AMG_OFS_CRC_MASK: reg_rdata_o <= crc_mask_reg;
					`AMG_OFS_CLK_MASK: reg_rdata_o <= clk_mask_reg;
					`AMG_OFS_TEMP_MASK: reg_rdata_o <= temp_mask_reg;
					`AMG_OFS_THERM_MASK: reg_rdata_o <= therm_mask_reg;
					default: reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Microsecond tick for the timers
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			us_div_reg <= 16'h0000;
			us_tick_reg <= 1'b0;
		end
		else if (us_div_reg >= 16'(US_TICK_CYCLES - 1))
		begin
			us_div_reg <= 16'h0000;
			us_tick_reg <= 1'b1;
		end
		else
		begin
			us_div_reg <= us_div_reg + 16'h0001;
			us_tick_reg <= 1'b0;
		end
	end

	always_comb
	begin
		hold_target = hold_us(gate_reg[`AMG_F_HOLD_HI:`AMG_F_HOLD_LO]);
		// Counting samples below 48 ksps stretches the time by 48/fs
		if (fs_below_48k_i)
			lvhys_target = 24'(lvhys_ms(ramp_lvhys_reg[`AMG_F_LVHYS_HI:`AMG_F_LVHYS_LO]) * SAMPLES_PER_MS);
		else
			lvhys_target = 24'(lvhys_ms(ramp_lvhys_reg[`AMG_F_LVHYS_HI:`AMG_F_LVHYS_LO]) * `AMG_US_PER_MS);
		lv_tick = fs_below_48k_i ? sample_tick_i : us_tick_reg;
	end

	// Silence must persist for the hold time before the gate closes
	amgirq_hold_timer #(
		.CW(`AMG_TIMER_W)
	) u_gate_timer (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.arm_i(silence_i && gate_reg[`AMG_F_GATE_EN]),
		.tick_i(us_tick_reg),
		.target_i(hold_target),
		.expired_o(gate_expired)
	);

	amgirq_hold_timer #(
		.CW(`AMG_TIMER_W)
	) u_lv_timer (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.arm_i(lowvolt_cond_i),
		.tick_i(lv_tick),
		.target_i(lvhys_target),
		.expired_o(lv_expired)
	);

	// Settings driven out to the signal path
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			gate_active_o <= 1'b0;
			gate_level_threshold_o <= RST_GATE_IMG[`AMG_F_LEVEL_HI:`AMG_F_LEVEL_LO];
			gate_volume_ramp_off_o <= RST_RAMP_IMG[`AMG_F_RAMP_OFF];
		end
		else
		begin
			gate_active_o <= gate_expired && gate_reg[`AMG_F_GATE_EN];
			gate_level_threshold_o <= gate_reg[`AMG_F_LEVEL_HI:`AMG_F_LEVEL_LO];
			gate_volume_ramp_off_o <= ramp_lvhys_reg[`AMG_F_RAMP_OFF];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			lowvolt_threshold_mode_o <= RST_LVTH_IMG[`AMG_F_LVMODE];
			lowvolt_fixed_threshold_o <= RST_LVTH_IMG[`AMG_F_LVFTH_HI:`AMG_F_LVFTH_LO];
			lowvolt_active_o <= 1'b0;
			pin_weak_pulldown_o <= RST_PD_IMG[`AMG_F_PD_HI:`AMG_F_PD_LO];
		end
		else
		begin
			lowvolt_threshold_mode_o <= lvth_reg[`AMG_F_LVMODE];
			lowvolt_fixed_threshold_o <= lvth_reg[`AMG_F_LVFTH_HI:`AMG_F_LVFTH_LO];
			lowvolt_active_o <= lv_expired;
			pin_weak_pulldown_o <= pulldown_reg[`AMG_F_PD_HI:`AMG_F_PD_LO];
		end
	end

	// Collect mask bits into source order
	always_comb
	begin
		mask_vec = '0;
		mask_vec[`AMG_E_BO_MUTE] = bo_mask_reg[`AMG_B_BO_MUTE];
		mask_vec[`AMG_E_BO_INFHOLD] = bo_mask_reg[`AMG_B_BO_INFHOLD];
		mask_vec[`AMG_E_CRC] = crc_mask_reg[`AMG_B_CRC];
		mask_vec[`AMG_E_LIMITER] = crc_mask_reg[`AMG_B_LIMITER];
		mask_vec[`AMG_E_CLKERR] = clk_mask_reg[`AMG_B_CLKERR];
		mask_vec[`AMG_E_TEMP1] = temp_mask_reg[`AMG_B_TEMP1];
		mask_vec[`AMG_E_TEMP2] = temp_mask_reg[`AMG_B_TEMP2];
		mask_vec[`AMG_E_TEMP3] = temp_mask_reg[`AMG_B_TEMP3];
		mask_vec[`AMG_E_TEMP4] = temp_mask_reg[`AMG_B_TEMP4];
		mask_vec[`AMG_E_REG_UV] = temp_mask_reg[`AMG_B_REG_UV];
		mask_vec[`AMG_E_HIGH_UV] = temp_mask_reg[`AMG_B_HIGH_UV];
		mask_vec[`AMG_E_TDTH2] = therm_mask_reg[`AMG_B_TDTH2];
		mask_vec[`AMG_E_TDTH1] = therm_mask_reg[`AMG_B_TDTH1];
		mask_vec[`AMG_E_RAILDIFF] = therm_mask_reg[`AMG_B_RAILDIFF];
		mask_vec[`AMG_E_BO_ACTIVE] = therm_mask_reg[`AMG_B_BO_ACTIVE];
		mask_vec[`AMG_E_BO_DETECT] = therm_mask_reg[`AMG_B_BO_DETECT];
		mask_vec[`AMG_E_BO_PDSTART] = therm_mask_reg[`AMG_B_BO_PDSTART];
	end

	// New events win over a clear in the same cycle
	always_comb
	begin
		if (flag_clear_i)
			flags_next = event_i;
		else
			flags_next = latched_flags_o | event_i;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			latched_flags_o <= '0;
		else
			latched_flags_o <= flags_next;
	end

	// Flags latch even when masked; unmasking lets a pending one through
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(latched_flags_o & ~mask_vec);
	end
endmodule

/* verification/amgirq_regs_asserts.sv */
// Purpose: Port-level checks for the gate, low-voltage, pull-down and mask bank
// Assumes: One clock mclk_i, synchronous active-low reset
// Notes: Bound to amgirq_regs from the testbench top file
`timescale 1ns/1ps
module amgirq_regs_asserts (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic silence_i,
	input wire logic lowvolt_cond_i,
	input wire logic [16:0] event_i,
	input wire logic flag_clear_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rd_valid_o,
	input wire logic gate_active_o,
	input wire logic [1:0] gate_level_threshold_o,
	input wire logic gate_volume_ramp_off_o,
	input wire logic lowvolt_threshold_mode_o,
	input wire logic [4:0] lowvolt_fixed_threshold_o,
	input wire logic lowvolt_active_o,
	input wire logic [4:0] pin_weak_pulldown_o,
	input wire logic [16:0] latched_flags_o,
	input wire logic irq_o
);
	logic [7:0] wd_q1;
	logic [7:0] wd_q2;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Write data two edges back, lined up with the mirror outputs
	always_ff @(posedge mclk_i)
	begin
		wd_q1 <= reg_wdata_i;
		wd_q2 <= wd_q1;
	end
	property p_rdv; reg_rd_valid_o == $past(reg_rd_i); endproperty
	a_rdv: assert property (p_rdv) else $error("read valid not one cycle after strobe");
	property p_unmapped; reg_rd_i && reg_addr_i == 8'h39 |=> reg_rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_level; reg_wr_i && reg_addr_i == 8'h35 |=> ##1 gate_level_threshold_o == wd_q2[4:3]; endproperty
	a_level: assert property (p_level) else $error("gate level output wrong");
	property p_ramp; reg_wr_i && reg_addr_i == 8'h36 |=> ##1 gate_volume_ramp_off_o == wd_q2[5]; endproperty
	a_ramp: assert property (p_ramp) else $error("ramp off output wrong");
	property p_lvcfg;
		reg_wr_i && reg_addr_i == 8'h37 |=> ##1
			{lowvolt_threshold_mode_o, lowvolt_fixed_threshold_o} == {wd_q2[7], wd_q2[4:0]};
	endproperty
	a_lvcfg: assert property (p_lvcfg) else $error("low-voltage config output wrong");
	property p_pd; reg_wr_i && reg_addr_i == 8'h38 |=> ##1 pin_weak_pulldown_o == wd_q2[6:2]; endproperty
	a_pd: assert property (p_pd) else $error("pull-down output wrong");
	property p_gate_drop; !silence_i |-> ##2 !gate_active_o; endproperty
	a_gate_drop: assert property (p_gate_drop) else $error("gate stays active without silence");
	property p_gate_rise; $rose(gate_active_o) |-> $past(silence_i) && $past(silence_i, 8); endproperty
	a_gate_rise: assert property (p_gate_rise) else $error("gate engaged without held silence");
	property p_lv_drop; !lowvolt_cond_i |-> ##2 !lowvolt_active_o; endproperty
	a_lv_drop: assert property (p_lv_drop) else $error("low-voltage stays active");
	property p_latch; event_i != 17'h0 |=> (latched_flags_o & $past(event_i)) == $past(event_i); endproperty
	a_latch: assert property (p_latch) else $error("event not latched");
	property p_clear; flag_clear_i && event_i == 17'h0 |=> latched_flags_o == 17'h0; endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");
	property p_irq_cause; irq_o |-> $past(latched_flags_o) != 17'h0; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without a latched flag");
endmodule

/* verification/amgirq_regs_test.sv */
// Purpose: Self-checking bench for the gate, low-voltage, pull-down and mask bank
// Assumes: Microsecond tick shortened to one clock
// Notes: Random data from an 8-bit shift register seeded with 99
`timescale 1ns/1ps
module amgirq_regs_test;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, silence_i = 1'b0, lowvolt_cond_i = 1'b0;
	logic fs_below_48k_i = 1'b0, sample_tick_i = 1'b0, flag_clear_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
	logic [16:0] event_i = 17'h0, latched_flags_o;
	logic reg_rd_valid_o, gate_active_o, gate_volume_ramp_off_o, lowvolt_threshold_mode_o, lowvolt_active_o, irq_o;
	logic [1:0] gate_level_threshold_o;
	logic [4:0] lowvolt_fixed_threshold_o, pin_weak_pulldown_o;
	int failures = 0, n_tests = 0, cyc = 0;
	logic [7:0] lfsr = 8'h63;
	logic [7:0] ofs [9] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h3b, 8'h3c, 8'h3d, 8'h40, 8'h41};
	logic [7:0] rstv [9] = '{8'hbd, 8'had, 8'ha8, 8'h00, 8'hfc, 8'hbb, 8'hdd, 8'hf6, 8'h14};
	logic [7:0] wm [9] = '{8'hfc, 8'hef, 8'h9f, 8'h7c, 8'hff, 8'h41, 8'h80, 8'hf9, 8'hfc};
	logic [7:0] shadow [9];
	int src_reg [17] = '{4, 4, 5, 5, 6, 7, 7, 7, 7, 7, 7, 8, 8, 8, 8, 8, 8};
	int src_bit [17] = '{7, 6, 6, 0, 7, 7, 6, 5, 4, 3, 0, 7, 6, 5, 4, 3, 2};
	amgirq_regs #(.US_TICK_CYCLES(1)) dut (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.silence_i, .lowvolt_cond_i, .fs_below_48k_i, .sample_tick_i, .event_i, .flag_clear_i, .reg_rdata_o,
		.reg_rd_valid_o, .gate_active_o, .gate_level_threshold_o, .gate_volume_ramp_off_o, .lowvolt_threshold_mode_o,
		.lowvolt_fixed_threshold_o, .lowvolt_active_o, .pin_weak_pulldown_o, .latched_flags_o, .irq_o);
	always #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			close_out();
		end
	end
	task automatic close_out();
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_sig(input string what, input logic [16:0] exp, input logic [16:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	function automatic logic [7:0] nxt(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic int hold_us(input int c);
		int t [8] = '{400, 600, 800, 2000, 10000, 50000, 100000, 1000000};
		return t[c];
	endfunction
	task automatic do_reset();
		rst_n_i = 1'b0;
		tick(8);
		rst_n_i = 1'b1;
		for (int i = 0; i < 9; i++)
			shadow[i] = rstv[i];
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		tick(1);
		reg_rd_i = 1'b0;
		chk_sig("read valid", 17'h1, {16'h0, reg_rd_valid_o});
		chk_reg($sformatf("register %h", a), exp, reg_rdata_o);
		tick(1);
	endtask
	task automatic chk_mirrors();
		chk_sig("mirrors", {shadow[0][4:3], shadow[1][5], shadow[2][7], shadow[2][4:0], shadow[3][6:2]},
			{gate_level_threshold_o, gate_volume_ramp_off_o, lowvolt_threshold_mode_o, lowvolt_fixed_threshold_o,
			pin_weak_pulldown_o});
	endtask
	task automatic irq_sweep();
		for (int i = 0; i < 17; i++)
		begin
			event_i = 17'h1 << i;
			tick(1);
			event_i = 17'h0;
			tick(1);
			chk_sig("flags", 17'h1 << i, latched_flags_o);
			chk_sig("irq", {16'h0, ~shadow[src_reg[i]][src_bit[i]]}, {16'h0, irq_o});
			flag_clear_i = 1'b1;
			tick(1);
			flag_clear_i = 1'b0;
			tick(1);
		end
	endtask
	// Waits for the gate or low-voltage output; counts cycles or sample ticks
	task automatic measure(input bit lv, input int lo, input int hi, input bit ticks);
		int n;
		int t;
		n = 0;
		t = 0;
		while (((lv ? lowvolt_active_o : gate_active_o) !== 1'b1) && n < 5000)
		begin
			sample_tick_i = ticks && (n % 4 == 3);
			t += int'(sample_tick_i);
			tick(1);
			n++;
		end
		sample_tick_i = 1'b0;
		if (ticks)
			n = t;
		chk_sig("hold count in range", 17'h1, {16'h0, n >= lo && n <= hi});
	endtask
	initial
	begin
		do_reset();
		for (int i = 0; i < 9; i++)
			rd(ofs[i], rstv[i]);
		chk_mirrors();
		irq_sweep();
		rd(8'h39, 8'h00);
		rd(8'h3e, 8'h00);
		wr(8'h39, 8'hff);
		rd(8'h38, 8'h00);
		for (int k = 0; k < 3; k++)
			for (int i = 0; i < 9; i++)
			begin
				lfsr = nxt(lfsr);
				reg_wdata_i = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : lfsr;
				shadow[i] = (rstv[i] & ~wm[i]) | (reg_wdata_i & wm[i]);
				wr(ofs[i], reg_wdata_i);
				rd(ofs[i], shadow[i]);
			end
		chk_mirrors();
		irq_sweep();
		wr(8'h3b, 8'hff);
		shadow[4] = 8'hff;
		event_i = 17'h1;
		tick(1);
		event_i = 17'h0;
		tick(2);
		chk_sig("masked irq", 17'h0, {16'h0, irq_o});
		wr(8'h3b, 8'h7c);
		chk_sig("unmasked irq", 17'h1, {16'h0, irq_o});
		flag_clear_i = 1'b1;
		event_i = 17'h2;
		tick(1);
		flag_clear_i = 1'b0;
		event_i = 17'h0;
		chk_sig("set beats clear", 17'h2, latched_flags_o);
		do_reset();
		rd(8'h35, 8'hbd);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h35, {3'(c), 5'h04});
			silence_i = 1'b1;
			measure(1'b0, hold_us(c), hold_us(c) + 6, 1'b0);
			silence_i = 1'b0;
			tick(3);
			chk_sig("gate released", 17'h0, {16'h0, gate_active_o});
		end
		wr(8'h35, 8'h00);
		silence_i = 1'b1;
		tick(500);
		chk_sig("gate disabled", 17'h0, {16'h0, gate_active_o});
		silence_i = 1'b0;
		wr(8'h36, 8'h0a);
		lowvolt_cond_i = 1'b1;
		measure(1'b1, 1000, 1006, 1'b0);
		lowvolt_cond_i = 1'b0;
		fs_below_48k_i = 1'b1;
		tick(3);
		chk_sig("low-voltage released", 17'h0, {16'h0, lowvolt_active_o});
		for (int c = 0; c < 3; c++)
		begin
			wr(8'h36, (c == 2) ? 8'h05 : 8'h0a + 8'(c));
			lowvolt_cond_i = 1'b1;
			measure(1'b1, (c == 1) ? 480 : 48, (c == 1) ? 481 : 49, 1'b1);
			lowvolt_cond_i = 1'b0;
			tick(3);
		end
		close_out();
	end
endmodule
bind amgirq_regs amgirq_regs_asserts u_chk (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
	.silence_i, .lowvolt_cond_i, .event_i, .flag_clear_i, .reg_rdata_o, .reg_rd_valid_o, .gate_active_o,
	.gate_level_threshold_o, .gate_volume_ramp_off_o, .lowvolt_threshold_mode_o, .lowvolt_fixed_threshold_o,
	.lowvolt_active_o, .pin_weak_pulldown_o, .latched_flags_o, .irq_o);
